// ---- hdl/multiport_switch.sv ----
// Four-master, three-slave multiport switch with fixed-priority arbitration.
//
// Function
// - Four master and three slave ports; connections run concurrently.
// - Every port carries 32-bit address and 32-bit data paths.
// - At most two transfers at once; the second must be a flash fetch.
// - Same-cycle contention for a slave goes to the higher-priority master.
// - Losers stay stalled until the owner finishes with that slave.
// - Equal-priority requesters rotate, starting after the last granted master.
// - Masters: fetch, load/store, DMA, network; slaves: flash, SRAM, bridge.
// - A master's priority can be raised temporarily for arbitration.
module multiport_switch #(
    parameter logic [switch_pkg::NUM_MASTERS-1:0][switch_pkg::PRIO_W-1:0] PRIO =
        switch_pkg::MASTER_PRIO
) (
    input  wire logic                                         CORE_CLK_I,
    input  wire logic                                         RSTN_I,
    input  wire switch_pkg::mreq_t [switch_pkg::NUM_MASTERS-1:0] M_REQ_I,
    output switch_pkg::mrsp_t      [switch_pkg::NUM_MASTERS-1:0] M_RSP_O,
    output switch_pkg::sreq_t      [switch_pkg::NUM_SLAVES-1:0]  S_REQ_O,
    input  wire switch_pkg::srsp_t [switch_pkg::NUM_SLAVES-1:0]  S_RSP_I
);
    import switch_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [1:0]                              rst_sync_r;
    logic                                    rst_n;
    sw_state_t                               st_r;
    sw_state_t                               st_nxt;
    logic [NUM_MASTERS-1:0]                  busy_m;
    logic                                    data_busy;
    logic [NUM_SLAVES-1:0][NUM_MASTERS-1:0]  req_mask;
    logic [NUM_MASTERS-1:0]                  elev;
    logic [NUM_SLAVES-1:0][ID_W-1:0]         win;
    logic [NUM_SLAVES-1:0]                   win_v;
    logic [NUM_SLAVES-1:0]                   take;
    logic                                    slot_taken;
    logic                                    fetch;
    logic [ID_W-1:0]                         wm;
    logic [ID_W-1:0]                         om;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Maps an address onto the slave port that serves it.
    function automatic logic [SID_W-1:0] decode(input logic [ADDR_W-1:0] a);
        case (a[REGION_HI:REGION_LO])
            REGION_FLASH:   decode = S_FLASH;
            REGION_SRAM:    decode = S_SRAM;
            REGION_PBRIDGE: decode = S_PBRIDGE;
            default:        decode = S_NONE;
        endcase
    endfunction

    // A transfer is an instruction fetch when the fetch port talks to flash.
    function automatic logic is_fetch(input logic [SID_W-1:0] s, input logic [ID_W-1:0] m);
        return (s == S_FLASH) && (m == M_IFETCH);
    endfunction

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------

    // The asynchronous reset is released through two flip-flops.
    // Assertion still acts at once; only the release is aligned to the clock,
    // so that no register leaves reset a cycle before its neighbours.
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    // Synchronised reset used by every other register of the switch.
    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------------
    // Occupancy and request masks
    // ------------------------------------------------------------------

    // Find masters already served and whether the single data slot is used.
    // A master that owns a slave may not start a second transfer elsewhere,
    // which keeps each master to one outstanding transfer at a time.
    always_comb begin
        busy_m    = '0;
        data_busy = 1'b0;
        for (int s = 0; s < NUM_SLAVES; s++) begin
            if (st_r.own_v[s]) begin
                busy_m[st_r.own_id[s]] = 1'b1;
                if (!is_fetch(SID_W'(s), st_r.own_id[s])) begin
                    data_busy = 1'b1;
                end
            end
        end
    end

    // Build each slave's requester set; a held slave sees no requests.
    // A master whose done pulse is showing is masked, so the request it still
    // holds in that cycle cannot start the same transfer a second time.
    always_comb begin
        req_mask = '0;
        for (int m = 0; m < NUM_MASTERS; m++) begin
            elev[m] = M_REQ_I[m].elev;
        end
        for (int s = 0; s < NUM_SLAVES; s++) begin
            for (int m = 0; m < NUM_MASTERS; m++) begin
                req_mask[s][m] = M_REQ_I[m].req
                    && (decode(M_REQ_I[m].addr) == SID_W'(s))
                    && !busy_m[m]
                    && !st_r.mrsp[m].done
                    && !st_r.own_v[s]
                    && (!data_busy || is_fetch(SID_W'(s), ID_W'(m)));
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-slave arbiters
    // ------------------------------------------------------------------

    // One arbiter per slave lets all three slaves pick their winners independently.
    // An arbiter's pointer moves only when its grant is taken, so a slave
    // held back by the data slot keeps its round-robin place.
    for (genvar g = 0; g < NUM_SLAVES; g++) begin : g_arb
        slot_arbiter #(
            .PRIO        (PRIO)
        ) u_arb (
            .clk_i       (CORE_CLK_I),
            .rst_n_i     (rst_n),
            .req_i       (req_mask[g]),
            .elev_i      (elev),
            .take_i      (take[g]),
            .win_o       (win[g]),
            .win_valid_o (win_v[g])
        );
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------

    // Completes owned transfers, answers unmapped ones and grants new owners.
    always_comb begin
        st_nxt     = st_r;
        take       = '0;
        slot_taken = 1'b0;
        fetch      = 1'b0;
        wm         = '0;
        om         = '0;
        for (int m = 0; m < NUM_MASTERS; m++) begin
            st_nxt.mrsp[m].done = 1'b0;
            st_nxt.mrsp[m].err  = 1'b0;
        end
        // Addresses outside every slave end at once with an error.
        // The error pulse lasts one cycle, and the master drops its request
        // in the cycle after it, as after any other completion.
        for (int m = 0; m < NUM_MASTERS; m++) begin
            if (M_REQ_I[m].req && !st_r.mrsp[m].done && !busy_m[m]
                && decode(M_REQ_I[m].addr) == S_NONE) begin
                st_nxt.mrsp[m].done  = 1'b1;
                st_nxt.mrsp[m].err   = 1'b1;
                st_nxt.mrsp[m].rdata = '0;
            end
        end
        // Slaves are visited from the lowest index, so when two data grants meet
        // in one cycle the lower slave wins and the other waits.
        for (int s = 0; s < NUM_SLAVES; s++) begin
            if (st_r.own_v[s]) begin
                // The owner keeps the slave until the slave acknowledges.
                // The slave is not granted again in the cycle it is released, so
                // it never sees a new request while its acknowledge still stands.
                if (S_RSP_I[s].ack) begin
                    om                    = st_r.own_id[s];
                    st_nxt.own_v[s]       = 1'b0;
                    st_nxt.sreq[s].req    = 1'b0;
                    st_nxt.mrsp[om].done  = 1'b1;
                    st_nxt.mrsp[om].rdata = S_RSP_I[s].rdata;
                end
            end else if (win_v[s]) begin
                wm    = win[s];
                fetch = is_fetch(SID_W'(s), wm);
                // Only one data transfer may join a concurrent flash fetch.
                if (fetch || !slot_taken) begin
                    take[s]              = 1'b1;
                    st_nxt.own_v[s]      = 1'b1;
                    st_nxt.own_id[s]     = wm;
                    st_nxt.sreq[s].req   = 1'b1;
                    st_nxt.sreq[s].we    = M_REQ_I[wm].we;
                    st_nxt.sreq[s].fetch = fetch;
                    st_nxt.sreq[s].mid   = wm;
                    st_nxt.sreq[s].addr  = M_REQ_I[wm].addr;
                    st_nxt.sreq[s].wdata = M_REQ_I[wm].wdata;
                    if (!fetch) begin
                        slot_taken = 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State register and outputs
    // ------------------------------------------------------------------

    // All switch state except the reset synchroniser and the arbiter pointers sits in one register.
    // It runs on the synchronised reset, whose copy clears as soon as the pin
    // asserts, so every output falls to zero without waiting for a clock.
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state register.
    // Each master sees its completion pulse, error flag and read data here.
    assign M_RSP_O = st_r.mrsp;

    // Each slave sees its owner's request, held until the slave acknowledges.
    assign S_REQ_O = st_r.sreq;

endmodule // multiport_switch

// ---- hdl/switch_pkg.sv ----
// Shared constants, carrier structs and state types of the multiport switch.
package switch_pkg;

    // ------------------------------------------------------------------
    // Port counts and path widths
    // ------------------------------------------------------------------
    localparam int NUM_MASTERS = 4;
    localparam int NUM_SLAVES  = 3;
    localparam int ADDR_W      = 32;
    localparam int DATA_W      = 32;
    localparam int ID_W        = 2;
    localparam int SID_W       = 2;
    localparam int PRIO_W      = 2;
    localparam int RANK_W      = PRIO_W + 1;

    // ------------------------------------------------------------------
    // Master and slave port assignment
    // ------------------------------------------------------------------
    localparam logic [ID_W-1:0]  M_IFETCH  = 2'h0;
    localparam logic [ID_W-1:0]  M_LDST    = 2'h1;
    localparam logic [ID_W-1:0]  M_DMA     = 2'h2;
    localparam logic [ID_W-1:0]  M_NET     = 2'h3;
    localparam logic [SID_W-1:0] S_FLASH   = 2'h0;
    localparam logic [SID_W-1:0] S_SRAM    = 2'h1;
    localparam logic [SID_W-1:0] S_PBRIDGE = 2'h2;
    localparam logic [SID_W-1:0] S_NONE    = 2'h3;

    // ------------------------------------------------------------------
    // Address map: the top nibble of the address selects the slave
    // ------------------------------------------------------------------
    localparam int         REGION_HI      = 31;
    localparam int         REGION_LO      = 28;
    localparam logic [3:0] REGION_FLASH   = 4'h0;
    localparam logic [3:0] REGION_SRAM    = 4'h4;
    localparam logic [3:0] REGION_PBRIDGE = 4'hc;

    // Fixed level of each master port, index 3 first; higher wins.
    localparam logic [NUM_MASTERS-1:0][PRIO_W-1:0] MASTER_PRIO = {2'h1, 2'h1, 2'h2, 2'h2};

    // ------------------------------------------------------------------
    // Carrier structs
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              req;
        logic              we;
        logic              elev;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mreq_t;

    typedef struct packed {
        logic              done;
        logic              err;
        logic [DATA_W-1:0] rdata;
    } mrsp_t;

    typedef struct packed {
        logic              req;
        logic              we;
        logic              fetch;
        logic [ID_W-1:0]   mid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } sreq_t;

    typedef struct packed {
        logic              ack;
        logic [DATA_W-1:0] rdata;
    } srsp_t;

    // ------------------------------------------------------------------
    // Module state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ID_W-1:0] last;
    } arb_state_t;

    typedef struct packed {
        logic [NUM_SLAVES-1:0]            own_v;
        logic [NUM_SLAVES-1:0][ID_W-1:0]  own_id;
        sreq_t [NUM_SLAVES-1:0]           sreq;
        mrsp_t [NUM_MASTERS-1:0]          mrsp;
    } sw_state_t;

endpackage

// ---- hdl/slot_arbiter.sv ----
// Priority and round-robin arbiter for one slave port of the switch.
module slot_arbiter #(
    parameter logic [switch_pkg::NUM_MASTERS-1:0][switch_pkg::PRIO_W-1:0] PRIO =
        switch_pkg::MASTER_PRIO
) (
    input  wire logic                                  clk_i,
    input  wire logic                                  rst_n_i,
    input  wire logic [switch_pkg::NUM_MASTERS-1:0]    req_i,
    input  wire logic [switch_pkg::NUM_MASTERS-1:0]    elev_i,
    input  wire logic                                  take_i,
    output logic      [switch_pkg::ID_W-1:0]           win_o,
    output logic                                       win_valid_o
);
    import switch_pkg::*;

    arb_state_t          st_r;
    arb_state_t          st_nxt;
    logic [RANK_W-1:0]   best;
    logic [ID_W-1:0]     cand;
    logic                found;

    // Elevation ranks a master above every non-elevated level.
    function automatic logic [RANK_W-1:0] rank(input logic e, input logic [PRIO_W-1:0] p);
        return {e, p};
    endfunction

    // Pick the best rank, then walk round from the last winner among ties.
    always_comb begin
        st_nxt = st_r;
        best   = '0;
        found  = 1'b0;
        cand   = st_r.last;
        win_o  = st_r.last;
        for (int i = 0; i < NUM_MASTERS; i++) begin
            if (req_i[i] && rank(elev_i[i], PRIO[i]) > best) begin
                best = rank(elev_i[i], PRIO[i]);
            end
        end
        for (int k = 1; k <= NUM_MASTERS; k++) begin
            cand = st_r.last + ID_W'(k);
            if (!found && req_i[cand] && rank(elev_i[cand], PRIO[cand]) == best) begin
                win_o = cand;
                found = 1'b1;
            end
        end
        win_valid_o = found;
        if (take_i) begin
            st_nxt.last = win_o;
        end
    end

    // State register.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule // slot_arbiter

// ---- sim/switch_monitor.sv ----
// Checker that watches the ports of the multiport switch.
module switch_monitor #(
    parameter logic [switch_pkg::NUM_MASTERS-1:0][switch_pkg::PRIO_W-1:0] PRIO =
        switch_pkg::MASTER_PRIO
) (
    input wire logic                                           CORE_CLK_I,
    input wire logic                                           RSTN_I,
    input wire switch_pkg::mreq_t [switch_pkg::NUM_MASTERS-1:0] M_REQ_I,
    input wire switch_pkg::mrsp_t [switch_pkg::NUM_MASTERS-1:0] M_RSP_O,
    input wire switch_pkg::sreq_t [switch_pkg::NUM_SLAVES-1:0]  S_REQ_O,
    input wire switch_pkg::srsp_t [switch_pkg::NUM_SLAVES-1:0]  S_RSP_I
);
    import switch_pkg::*;
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic [NUM_MASTERS-1:0][RANK_W-1:0] rk, rk_q;
    logic [NUM_SLAVES-1:0][RANK_W-1:0]  best, best_q;
    logic [NUM_SLAVES-1:0][ID_W-1:0]    mid_q;
    logic [NUM_SLAVES-1:0][DATA_W-1:0]  rd_q;
    logic [NUM_SLAVES-1:0]              dat;

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    function automatic logic [SID_W-1:0] slave_of(input logic [ADDR_W-1:0] a);
        case (a[REGION_HI:REGION_LO])
            REGION_FLASH:   return S_FLASH;
            REGION_SRAM:    return S_SRAM;
            REGION_PBRIDGE: return S_PBRIDGE;
            default:        return S_NONE;
        endcase
    endfunction

    // Highest rank among the live requesters of each slave, and the data-slot users.
    always_comb begin
        best = '0;
        for (int m = 0; m < NUM_MASTERS; m++) begin
            rk[m] = {M_REQ_I[m].elev, PRIO[m]};
        end
        for (int s = 0; s < NUM_SLAVES; s++) begin
            dat[s] = S_REQ_O[s].req && !S_REQ_O[s].fetch;
            for (int m = 0; m < NUM_MASTERS; m++) begin
                if (M_REQ_I[m].req && !M_RSP_O[m].done && slave_of(M_REQ_I[m].addr) == s[1:0]
                    && rk[m] > best[s]) begin
                    best[s] = rk[m];
                end
            end
        end
    end

    // One-cycle copies so that grants and completions can be judged against their cause.
    always_ff @(posedge CORE_CLK_I) begin
        rk_q   <= rk;
        best_q <= best;
        for (int s = 0; s < NUM_SLAVES; s++) begin
            mid_q[s] <= S_REQ_O[s].mid;
            rd_q[s]  <= S_RSP_I[s].rdata;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    for (genvar s = 0; s < NUM_SLAVES; s++) begin : g_s
        sequence s_ack;
            S_REQ_O[s].req && S_RSP_I[s].ack;
        endsequence
        sequence s_finish;
            !S_REQ_O[s].req && M_RSP_O[mid_q[s]].done && !M_RSP_O[mid_q[s]].err;
        endsequence
        property p_route;
            S_REQ_O[s].req |-> slave_of(S_REQ_O[s].addr) == SID_W'(s)
                && M_REQ_I[S_REQ_O[s].mid].req && M_REQ_I[S_REQ_O[s].mid].addr == S_REQ_O[s].addr
                && M_REQ_I[S_REQ_O[s].mid].we == S_REQ_O[s].we
                && M_REQ_I[S_REQ_O[s].mid].wdata == S_REQ_O[s].wdata;
        endproperty
        a_route: assert property (p_route) else $error("slave request not from its owner");
        property p_hold;
            S_REQ_O[s].req && !S_RSP_I[s].ack |=> S_REQ_O[s].req && $stable(S_REQ_O[s]);
        endproperty
        a_hold: assert property (p_hold) else $error("slave request changed before ack");
        property p_finish;
            s_ack |=> s_finish;
        endproperty
        a_finish: assert property (p_finish) else $error("acked transfer not completed");
        property p_rdata;
            s_ack and !S_REQ_O[s].we |=> M_RSP_O[mid_q[s]].rdata == rd_q[s];
        endproperty
        a_rdata: assert property (p_rdata) else $error("read data not returned");
        property p_prio;
            $rose(S_REQ_O[s].req) |-> rk_q[S_REQ_O[s].mid] >= best_q[s];
        endproperty
        a_prio: assert property (p_prio) else $error("grant went to a lower rank");
    end

    for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_m
        property p_pulse;
            M_RSP_O[m].done |=> !M_RSP_O[m].done;
        endproperty
        a_pulse: assert property (p_pulse) else $error("done held longer than one cycle");
        property p_unmapped;
            $rose(M_REQ_I[m].req) && slave_of(M_REQ_I[m].addr) == S_NONE
                |=> M_RSP_O[m].done && M_RSP_O[m].err;
        endproperty
        a_unmapped: assert property (p_unmapped) else $error("unmapped request not refused");
    end

    property p_one_data;
        $countones(dat) <= 1;
    endproperty
    a_one_data: assert property (p_one_data) else $error("two data transfers at once");
    property p_fetch;
        !S_REQ_O[1].fetch && !S_REQ_O[2].fetch
            && (!S_REQ_O[0].req || S_REQ_O[0].fetch == (S_REQ_O[0].mid == M_IFETCH));
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch marker wrong");
endmodule // switch_monitor

bind multiport_switch switch_monitor #(.PRIO(PRIO)) i_switch_monitor (
    .CORE_CLK_I(CORE_CLK_I),
    .RSTN_I    (RSTN_I),
    .M_REQ_I   (M_REQ_I),
    .M_RSP_O   (M_RSP_O),
    .S_REQ_O   (S_REQ_O),
    .S_RSP_I   (S_RSP_I)
);

// ---- sim/mem_slave_model.sv ----
// Behavioural memory slave that answers the switch after a set wait.
module mem_slave_model #(
    parameter int LAT = 0
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire switch_pkg::sreq_t req_i,
    output switch_pkg::srsp_t      rsp_o
);
    import switch_pkg::*;
    int unsigned       cnt_r;
    logic [DATA_W-1:0] free_r;

    // Ack after LAT waiting cycles; outside an ack the data churns so stale data never passes.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r  <= 0;
            free_r <= '0;
            rsp_o  <= '0;
        end else begin
            free_r      <= free_r + 32'h1;
            rsp_o.ack   <= 1'b0;
            rsp_o.rdata <= ~free_r;
            if (req_i.req && !rsp_o.ack) begin
                if (cnt_r == LAT) begin
                    rsp_o.ack   <= 1'b1;
                    rsp_o.rdata <= ~req_i.addr;
                    cnt_r       <= 0;
                end else begin
                    cnt_r <= cnt_r + 1;
                end
            end
        end
    end
endmodule // mem_slave_model

// ---- sim/tb_multiport_switch.sv ----
// Self-checking testbench of the multiport switch.
module tb_multiport_switch;
    timeunit 1ns;
    timeprecision 1ps;
    import switch_pkg::*;
    // ------------------------------------------------------------------
    // Signals, design and slave models
    // ------------------------------------------------------------------
    logic                          clk = 1'b0;
    logic                          rst_n = 1'b0;
    mreq_t [NUM_MASTERS-1:0]       m_req = '0;
    wire mrsp_t [NUM_MASTERS-1:0]  m_rsp;
    wire sreq_t [NUM_SLAVES-1:0]   s_req;
    wire srsp_t [NUM_SLAVES-1:0]   s_rsp;
    logic [3:0]                    rg [NUM_SLAVES] = '{REGION_FLASH, REGION_SRAM, REGION_PBRIDGE};
    int                            n_errors = 0;
    int                            comparisons = 0;

    multiport_switch i_multiport_switch (.CORE_CLK_I(clk), .RSTN_I(rst_n), .M_REQ_I(m_req),
        .M_RSP_O(m_rsp), .S_REQ_O(s_req), .S_RSP_I(s_rsp));
    // Slaves wait 0, 2 and 4 cycles, so prompt and slow answers both occur.
    for (genvar s = 0; s < NUM_SLAVES; s++) begin : g_slv
        mem_slave_model #(.LAT(2 * s)) i_mem_slave_model (.clk_i(clk), .rst_n_i(rst_n),
            .req_i(s_req[s]), .rsp_o(s_rsp[s]));
    end

    // Clock, and a watchdog that cuts a hang short.
    initial forever #10 clk = ~clk;
    initial begin
        #100us;
        n_errors++;
        final_report();
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One transfer by master m; returns data, error flag and completion time.
    task automatic xfer(input int m, input logic [ADDR_W-1:0] a, input logic we, input logic el,
                        output logic [DATA_W-1:0] rd, output logic er, output time t);
        @(posedge clk);
        m_req[m] <= '{req: 1'b1, we: we, elev: el, addr: a, wdata: a ^ 32'h5a};
        t = 0;
        for (int i = 0; i < 200 && t == 0; i++) begin
            @(posedge clk);
            #1;
            if (m_rsp[m].done === 1'b1) begin
                t  = $time;
                rd = m_rsp[m].rdata;
                er = m_rsp[m].err;
            end
        end
        check({31'h0, t != 0}, 32'h1);
        @(posedge clk);
        m_req[m].req <= 1'b0;
    endtask

    task automatic t_routes();
        logic [DATA_W-1:0] a, r;
        logic e;
        time t;
        for (int m = 0; m < NUM_MASTERS; m++) begin
            for (int s = 0; s < NUM_SLAVES; s++) begin
                a = {rg[s], 28'(32'h100 * m + 4 * s)};
                xfer(m, a, m == s, 1'b0, r, e, t);
                check({31'h0, e}, 32'h0);
                if (m != s) check(r, ~a);
            end
        end
        xfer(2, 32'h8000_0010, 1'b0, 1'b0, r, e, t);
        check({31'h0, e}, 32'h1);
    endtask

    task automatic t_prio(input logic el);
        logic [DATA_W-1:0] r1, r3;
        logic e1, e3;
        time t1, t3;
        fork
            xfer(1, 32'h4000_0100, 1'b0, 1'b0, r1, e1, t1);
            xfer(3, 32'h4000_0300, 1'b0, el, r3, e3, t3);
        join
        check({31'h0, (t1 < t3) != el}, 32'h1);
        check(r1, ~32'h4000_0100);
        check(r3, ~32'h4000_0300);
    endtask

    task automatic t_rr(input int a, input int b);
        logic [DATA_W-1:0] r;
        logic e;
        time ta, tb;
        xfer(a, 32'hc000_0040, 1'b0, 1'b0, r, e, ta);
        fork
            xfer(a, 32'hc000_0080, 1'b0, 1'b0, r, e, ta);
            xfer(b, 32'hc000_00c0, 1'b0, 1'b0, r, e, tb);
        join
        check({31'h0, tb < ta}, 32'h1);
    endtask

    task automatic t_concurrent(input int m, input logic [ADDR_W-1:0] a, input int s, input logic exp);
        logic [DATA_W-1:0] r1, r2;
        logic e1, e2;
        logic both;
        time t1, t2;
        both = 1'b0;
        fork
            xfer(m, a, 1'b0, 1'b0, r1, e1, t1);
            xfer(1, 32'h4000_0200, 1'b0, 1'b0, r2, e2, t2);
            repeat (20) begin
                @(posedge clk);
                #1;
                if (s_req[s].req === 1'b1 && s_req[1].req === 1'b1) both = 1'b1;
            end
        join
        check({31'h0, both}, {31'h0, exp});
        check(r1, ~a);
    endtask

    // Reset in mid-transfer: the owned slave request and every response clear at once.
    task automatic t_reset();
        @(posedge clk);
        m_req[2] <= '{req: 1'b1, we: 1'b0, elev: 1'b0, addr: 32'hc000_0700, wdata: 32'h0};
        repeat (2) @(posedge clk);
        #1;
        check({31'h0, s_req[2].req}, 32'h1);
        @(posedge clk);
        rst_n        <= 1'b0;
        m_req[2].req <= 1'b0;
        #1;
        check({31'h0, |{s_req, m_rsp}}, 32'h0);
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    task automatic final_report();
        $display("TB: errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence: reset for ten cycles, then the scenarios.
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_routes();
        t_reset();
        t_prio(1'b0);
        t_prio(1'b1);
        t_rr(2, 3);
        t_rr(3, 2);
        t_concurrent(0, 32'h0000_0500, 0, 1'b1);
        t_concurrent(2, 32'hc000_0600, 2, 1'b0);
        final_report();
    end
endmodule // tb_multiport_switch
